/* File: design/rfs_cfg.svh */
`ifndef RFS_CFG_SVH
`define RFS_CFG_SVH

// register offsets
`define RFS_OFS_DIAG   8'h00
`define RFS_OFS_SWCFG  8'h01
`define RFS_OFS_STCFG  8'h02
`define RFS_OFS_OUTPUT_LEVEL_CODE   8'h03
`define RFS_OFS_CMD    8'h04

// diagnostic and command field positions
`define RFS_BIT_OC     7
`define RFS_BIT_TSD    6
`define RFS_BIT_TWRN   5
`define RFS_BIT_RSVF   4
`define RFS_BIT_GATE   3
`define RFS_BIT_ONE    2
`define RFS_BIT_NOFLT  1
`define RFS_BIT_OK     0
`define RFS_BIT_CLR    0

// implemented bits of the configuration registers
`define RFS_SWCFG_MASK 8'hf8
`define RFS_STCFG_MASK 8'h7f

// reset values (factory defaults, arbitrary here)
`define RFS_RST_SWCFG  8'h00
`define RFS_RST_STCFG  8'h00
`define RFS_RST_OUTPUT_LEVEL_CODE   8'h00
`define RFS_RST_CMD    8'h00

// serial slave address, value is arbitrary
`define RFS_DEV_ADDR   7'h2a

// bit counter marks
`define RFS_CNT_ACK    4'h8
`define RFS_CNT_ACKE   4'h9

`endif

/* File: design/rfs_pkg.sv */
package rfs_pkg;

	typedef enum logic [2:0] {
		RFS_IDLE   = 3'b000,
		RFS_DEVADR = 3'b001,
		RFS_REGADR = 3'b010,
		RFS_WRITE  = 3'b011,
		RFS_READ   = 3'b100
	} rfs_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rfs_wr_req_t;

	typedef struct packed {
		logic oc;
		logic tsd;
		logic twrn;
	} rfs_flags_t;

	typedef struct packed {
		logic [1:0] cur_limit;
		logic [2:0] freq;
		logic [2:0] startup_dly;
		logic [1:0] margin;
		logic [1:0] softstart;
		logic [7:0] output_level_code;
	} rfs_cfg_t;

endpackage

/* File: design/rfs_regs.sv */
`timescale 1ns/1ps
`include "rfs_cfg.svh"

module rfs_regs #(
	parameter logic [6:0] DEV_ADDR  = `RFS_DEV_ADDR,
	parameter logic [7:0] RST_SWCFG = `RFS_RST_SWCFG,
	parameter logic [7:0] RST_STCFG = `RFS_RST_STCFG,
	parameter logic [7:0] RST_OUTPUT_LEVEL_CODE  = `RFS_RST_OUTPUT_LEVEL_CODE
) (
	// register clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// serial link, oversampled on its own clock
	input  wire logic              link_clk,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_o,
	output logic                   sda_oe,
	// fault and pin levels from the regulator
	input  wire logic              overcurrent_in,
	input  wire logic              thermal_shutdown_in,
	input  wire logic              thermal_warning_in,
	input  wire logic              gate_pin_in,
	input  wire logic              output_ok_pin,
	// configuration fields and fault flags to the regulator
	output rfs_pkg::rfs_cfg_t      cfg_o,
	output rfs_pkg::rfs_flags_t    flags_o
);

	// general call would turn every host write into a hit
	if (DEV_ADDR == 7'h00) begin
		$error("general call address cannot be the slave address");
	end

	function automatic logic [7:0] diag_byte(
		input rfs_pkg::rfs_flags_t f,
		input logic                gate,
		input logic                ok
	);
		logic [7:0] b;
		b = 8'h00;
		b[`RFS_BIT_OC]    = f.oc;
		b[`RFS_BIT_TSD]   = f.tsd;
		b[`RFS_BIT_TWRN]  = f.twrn;
		b[`RFS_BIT_GATE]  = gate;
		b[`RFS_BIT_ONE]   = 1'b1;
		b[`RFS_BIT_NOFLT] = ~(f.oc | f.tsd | f.twrn);
		b[`RFS_BIT_OK]    = ok;
		return b;
	endfunction

	// ---------------- register domain ----------------

	// pin synchronisers: first stage read only by second
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	logic [2:0] wtog_s_r;
	logic [2:0] rtog_s_r;

	logic                 wtog_r;
	rfs_pkg::rfs_wr_req_t wreq_r;
	logic                 rtog_r;
	logic [7:0]           raddr_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_s1_r <= 5'h00;
			pin_s2_r <= 5'h00;
			wtog_s_r <= 3'h0;
			rtog_s_r <= 3'h0;
		end else begin
			pin_s1_r <= {overcurrent_in, thermal_shutdown_in,
				thermal_warning_in, gate_pin_in, output_ok_pin};
			pin_s2_r <= pin_s1_r;
			wtog_s_r <= {wtog_s_r[1:0], wtog_r};
			rtog_s_r <= {rtog_s_r[1:0], rtog_r};
		end
	end

	logic wr_ev;
	logic rd_ev;
	assign wr_ev = wtog_s_r[2] ^ wtog_s_r[1];
	assign rd_ev = rtog_s_r[2] ^ rtog_s_r[1];

	rfs_pkg::rfs_flags_t flags_r;
	rfs_pkg::rfs_flags_t flags_nxt;
	logic [7:0]          swcfg_r;
	logic [7:0]          swcfg_nxt;
	logic [7:0]          stcfg_r;
	logic [7:0]          stcfg_nxt;
	logic [7:0]          output_level_code_r;
	logic [7:0]          output_level_code_nxt;
	logic [7:0]          cmd_r;
	logic [7:0]          cmd_nxt;
	logic [7:0]          rdat_r;
	logic [7:0]          rdat_nxt;
	logic                rack_r;
	logic                rack_nxt;
	logic                clr;

	// write data is stable for a whole byte time when the toggle lands
	always_comb begin
		swcfg_nxt = swcfg_r;
		stcfg_nxt = stcfg_r;
		output_level_code_nxt  = output_level_code_r;
		cmd_nxt   = cmd_r;
		clr       = 1'b0;
		if (wr_ev) begin
			case (wreq_r.addr)
				`RFS_OFS_SWCFG: swcfg_nxt = wreq_r.data & `RFS_SWCFG_MASK;
				`RFS_OFS_STCFG: stcfg_nxt = wreq_r.data & `RFS_STCFG_MASK;
				`RFS_OFS_OUTPUT_LEVEL_CODE:  output_level_code_nxt  = wreq_r.data;
				`RFS_OFS_CMD: begin
					cmd_nxt = wreq_r.data;
					// upper command bits are stored only
					clr = wreq_r.data[`RFS_BIT_CLR];
				end
				default: ;
			endcase
		end
		// set wins over a clear in the same cycle
		flags_nxt.oc   = (flags_r.oc & ~clr) | pin_s2_r[4];
		flags_nxt.tsd  = (flags_r.tsd & ~clr) | pin_s2_r[3];
		flags_nxt.twrn = (flags_r.twrn & ~clr) | pin_s2_r[2];
		rdat_nxt = rdat_r;
		rack_nxt = rack_r;
		if (rd_ev) begin
			rack_nxt = ~rack_r;
			case (raddr_r)
				`RFS_OFS_DIAG:
					rdat_nxt = diag_byte(flags_r, pin_s2_r[1],
						pin_s2_r[0]);
				`RFS_OFS_SWCFG: rdat_nxt = swcfg_r;
				`RFS_OFS_STCFG: rdat_nxt = stcfg_r;
				`RFS_OFS_OUTPUT_LEVEL_CODE:  rdat_nxt = output_level_code_r;
				`RFS_OFS_CMD:   rdat_nxt = cmd_r;
				default:        rdat_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			flags_r <= '0;
			swcfg_r <= RST_SWCFG;
			stcfg_r <= RST_STCFG;
			output_level_code_r  <= RST_OUTPUT_LEVEL_CODE;
			cmd_r   <= `RFS_RST_CMD;
			rdat_r  <= 8'h00;
			rack_r  <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			swcfg_r <= swcfg_nxt;
			stcfg_r <= stcfg_nxt;
			output_level_code_r  <= output_level_code_nxt;
			cmd_r   <= cmd_nxt;
			rdat_r  <= rdat_nxt;
			rack_r  <= rack_nxt;
		end
	end

	assign flags_o           = flags_r;
	assign cfg_o.cur_limit   = swcfg_r[7:6];
	assign cfg_o.freq        = swcfg_r[5:3];
	assign cfg_o.startup_dly = stcfg_r[6:4];
	assign cfg_o.margin      = stcfg_r[3:2];
	assign cfg_o.softstart   = stcfg_r[1:0];
	assign cfg_o.output_level_code        = output_level_code_r;

	// ---------------- link domain ----------------

	logic [1:0] lrst_s_r;
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic [2:0] rack_s_r;
	logic       lrst_b;

	// reset is carried over as a level; link_clk runs free
	always_ff @(posedge link_clk) begin
		lrst_s_r <= {lrst_s_r[0], rst_b};
	end
	assign lrst_b = lrst_s_r[1];

	always_ff @(posedge link_clk) begin
		if (!lrst_b) begin
			scl_s_r  <= 3'h7;
			sda_s_r  <= 3'h7;
			rack_s_r <= 3'h0;
		end else begin
			scl_s_r  <= {scl_s_r[1:0], scl_in};
			sda_s_r  <= {sda_s_r[1:0], sda_in};
			rack_s_r <= {rack_s_r[1:0], rack_r};
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_now;
	assign sda_now   = sda_s_r[1];
	assign scl_rise  = scl_s_r[1] & ~scl_s_r[2];
	assign scl_fall  = ~scl_s_r[1] & scl_s_r[2];
	assign bus_start = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_now;
	assign bus_stop  = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_now;

	rfs_pkg::rfs_state_t  st_r;
	rfs_pkg::rfs_state_t  st_nxt;
	logic [3:0]           cnt_r;
	logic [3:0]           cnt_nxt;
	logic [7:0]           sh_r;
	logic [7:0]           sh_nxt;
	logic [7:0]           ptr_r;
	logic [7:0]           ptr_nxt;
	logic [7:0]           tx_r;
	logic [7:0]           tx_nxt;
	logic                 oe_r;
	logic                 oe_nxt;
	logic                 hit_r;
	logic                 hit_nxt;
	logic                 mack_r;
	logic                 mack_nxt;
	logic                 wtog_nxt;
	rfs_pkg::rfs_wr_req_t wreq_nxt;
	logic                 rtog_nxt;
	logic [7:0]           raddr_nxt;

	// byte engine: address byte, register pointer, then data bytes
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		ptr_nxt   = ptr_r;
		tx_nxt    = tx_r;
		oe_nxt    = oe_r;
		hit_nxt   = hit_r;
		mack_nxt  = mack_r;
		wtog_nxt  = wtog_r;
		wreq_nxt  = wreq_r;
		rtog_nxt  = rtog_r;
		raddr_nxt = raddr_r;
		// read data returns well before the byte that needs it
		if (rack_s_r[2] ^ rack_s_r[1])
			tx_nxt = rdat_r;
		if (bus_stop) begin
			st_nxt = rfs_pkg::RFS_IDLE;
			oe_nxt = 1'b0;
		end else if (bus_start) begin
			st_nxt  = rfs_pkg::RFS_DEVADR;
			cnt_nxt = 4'h0;
			oe_nxt  = 1'b0;
		end else if (st_r != rfs_pkg::RFS_IDLE) begin
			if (scl_rise) begin
				if (cnt_r < `RFS_CNT_ACK) begin
					if (st_r != rfs_pkg::RFS_READ)
						sh_nxt = {sh_r[6:0], sda_now};
					cnt_nxt = 4'(cnt_r + 4'h1);
				end else if (cnt_r == `RFS_CNT_ACK) begin
					cnt_nxt  = `RFS_CNT_ACKE;
					mack_nxt = sda_now;
				end
			end else if (scl_fall) begin
				if (cnt_r == `RFS_CNT_ACK) begin
					case (st_r)
						rfs_pkg::RFS_DEVADR: begin
							hit_nxt = (sh_r[7:1] == DEV_ADDR);
							oe_nxt  = hit_nxt;
							if (hit_nxt && sh_r[0]) begin
								rtog_nxt  = ~rtog_r;
								raddr_nxt = ptr_r;
							end
						end
						rfs_pkg::RFS_REGADR: begin
							ptr_nxt = sh_r;
							oe_nxt  = 1'b1;
						end
						rfs_pkg::RFS_WRITE: begin
							wreq_nxt.addr = ptr_r;
							wreq_nxt.data = sh_r;
							wtog_nxt      = ~wtog_r;
							oe_nxt        = 1'b1;
						end
						rfs_pkg::RFS_READ: begin
							ptr_nxt   = 8'(ptr_r + 8'h01);
							rtog_nxt  = ~rtog_r;
							raddr_nxt = 8'(ptr_r + 8'h01);
							oe_nxt    = 1'b0;
						end
						default: oe_nxt = 1'b0;
					endcase
				end else if (cnt_r == `RFS_CNT_ACKE) begin
					cnt_nxt = 4'h0;
					oe_nxt  = 1'b0;
					case (st_r)
						rfs_pkg::RFS_DEVADR: begin
							if (!hit_r)
								st_nxt = rfs_pkg::RFS_IDLE;
							else if (sh_r[0]) begin
								st_nxt = rfs_pkg::RFS_READ;
								sh_nxt = tx_r;
								oe_nxt = ~tx_r[7];
							end else
								st_nxt = rfs_pkg::RFS_REGADR;
						end
						rfs_pkg::RFS_REGADR: st_nxt = rfs_pkg::RFS_WRITE;
						rfs_pkg::RFS_WRITE:  ptr_nxt = 8'(ptr_r + 8'h01);
						rfs_pkg::RFS_READ: begin
							if (mack_r)
								st_nxt = rfs_pkg::RFS_IDLE;
							else begin
								sh_nxt = tx_r;
								oe_nxt = ~tx_r[7];
							end
						end
						default: st_nxt = rfs_pkg::RFS_IDLE;
					endcase
				end else if (st_r == rfs_pkg::RFS_READ &&
					cnt_r != 4'h0) begin
					sh_nxt = {sh_r[6:0], 1'b0};
					oe_nxt = ~sh_r[6];
				end
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (!lrst_b) begin
			st_r    <= rfs_pkg::RFS_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			ptr_r   <= 8'h00;
			tx_r    <= 8'h00;
			oe_r    <= 1'b0;
			hit_r   <= 1'b0;
			mack_r  <= 1'b1;
			wtog_r  <= 1'b0;
			wreq_r  <= '0;
			rtog_r  <= 1'b0;
			raddr_r <= 8'h00;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= ptr_nxt;
			tx_r    <= tx_nxt;
			oe_r    <= oe_nxt;
			hit_r   <= hit_nxt;
			mack_r  <= mack_nxt;
			wtog_r  <= wtog_nxt;
			wreq_r  <= wreq_nxt;
			rtog_r  <= rtog_nxt;
			raddr_r <= raddr_nxt;
		end
	end

	// open drain: only ever pull low
	assign sda_o  = 1'b0;
	assign sda_oe = oe_r & lrst_b;

endmodule

/* File: test/rfs_chk.sv */
`timescale 1ns/1ps
module rfs_chk (
	// clock and reset
	input wire logic                clk,
	input wire logic                rst_b,
	// serial pins
	input wire logic                scl_in,
	input wire logic                sda_o,
	input wire logic                sda_oe,
	// fault levels
	input wire logic                overcurrent_in,
	input wire logic                thermal_shutdown_in,
	input wire logic                thermal_warning_in,
	// register outputs
	input wire rfs_pkg::rfs_cfg_t   cfg_o,
	input wire rfs_pkg::rfs_flags_t flags_o
);
	logic [9:0] idle_r;
	logic [9:0] idle_nxt;
	// age of last device drive, saturating
	always_comb begin
		idle_nxt = idle_r;
		if (!rst_b)
			idle_nxt = 10'h3ff;
		else if (sda_oe)
			idle_nxt = 10'h000;
		else if (idle_r != 10'h3ff)
			idle_nxt = idle_r + 10'h001;
	end
	always_ff @(posedge clk) begin
		idle_r <= idle_nxt;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	AST_SDA_LOW: assert property (!sda_o)
		else $error("sda value not low");
	AST_OE_SCL: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda drive moved with scl high");
	AST_OC_SET: assert property (
		overcurrent_in [*4] |-> ##[0:2] flags_o.oc)
		else $error("oc flag not set");
	AST_TSD_SET: assert property (
		thermal_shutdown_in [*4] |-> ##[0:2] flags_o.tsd)
		else $error("tsd flag not set");
	AST_TWRN_SET: assert property (
		thermal_warning_in [*4] |-> ##[0:2] flags_o.twrn)
		else $error("twrn flag not set");
	// apart from reset, a bus write is the only way to drop a flag
	AST_FLAG_HOLD: assert property (
		|(~flags_o & $past(flags_o)) |-> idle_r < 10'h258)
		else $error("flag dropped without bus write");
	AST_CFG_WR: assert property (
		$changed(cfg_o) |-> idle_r < 10'h258)
		else $error("config moved without bus write");
	AST_RST_VAL: assert property (disable iff (1'b0)
		!rst_b |=> flags_o == 3'h0 && cfg_o == 20'h0)
		else $error("reset values wrong");
	COV_CLR: cover property ($fell(flags_o.oc));
	COV_CFG: cover property ($changed(cfg_o));
	COV_ACK: cover property ($rose(sda_oe));
endmodule

bind rfs_regs rfs_chk rfs_chk_inst (.clk, .rst_b, .scl_in, .sda_o,
	.sda_oe, .overcurrent_in, .thermal_shutdown_in,
	.thermal_warning_in, .cfg_o, .flags_o);

/* File: test/rfs_host.sv */
`timescale 1ns/1ps
module rfs_host #(
	parameter int H = 21
) (
	// timing base and wire level
	input wire logic clk,
	input wire logic sda_in,
	// host pins, sda_dr high pulls low
	output logic     scl,
	output logic     sda_dr
);
	initial begin
		scl = 1'b1;
		sda_dr = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// sda only moves mid scl low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		w(H / 2);
		sda_dr <= ~b;
		w(H - H / 2);
		scl <= 1'b1;
		w(H / 2);
		r = sda_in;
		w(H - H / 2);
	endtask
	// a=0 gives start or repeated start, a=1 gives stop
	task automatic ss(input logic a);
		scl <= 1'b0;
		w(H / 2);
		sda_dr <= a;
		w(H / 2);
		scl <= 1'b1;
		w(H / 2);
		sda_dr <= ~a;
		w(H / 2);
	endtask
	task automatic tx(input logic [7:0] b, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, nak);
	endtask
	task automatic rx(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(last, r);
	endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
`include "rfs_cfg.svh"
module testbench;
	logic                clk, link_clk, rst_b, scl, sda_dr, k;
	logic                oc, tsd, twrn, gate, ok, sda_o, sda_oe;
	logic [2:0]          acc, f;
	logic [7:0]          v;
	logic [7:0]          wb [3];
	logic [7:0]          rb [3];
	logic [31:0]         sd;
	int                  err_count, checked, cyc;
	rfs_pkg::rfs_cfg_t   cfg_o;
	rfs_pkg::rfs_flags_t flags_o;
	// pull-up when nobody pulls
	wire sda = ~(sda_dr | (sda_oe & ~sda_o));

	rfs_regs rfs_regs_inst (.clk, .rst_b, .link_clk, .scl_in(scl),
		.sda_in(sda), .sda_o, .sda_oe, .overcurrent_in(oc),
		.thermal_shutdown_in(tsd), .thermal_warning_in(twrn),
		.gate_pin_in(gate), .output_ok_pin(ok), .cfg_o, .flags_o);
	rfs_host rfs_host_inst (.clk, .sda_in(sda), .scl, .sda_dr);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] dexp(input logic [2:0] fl,
		input logic g, input logic o);
		return {fl, 1'b0, g, 1'b1, ~|fl, o};
	endfunction
	task automatic rnd(output logic [7:0] r);
		repeat (8) sd = lfsr(sd);
		r = sd[7:0];
	endtask
	task automatic chk(input string n, input logic [19:0] s, e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input int n);
		rfs_host_inst.ss(1'b0);
		rfs_host_inst.tx({`RFS_DEV_ADDR, 1'b0}, k);
		chk("addr ack", k, 1'b0);
		rfs_host_inst.tx(a, k);
		for (int i = 0; i < n; i++)
			rfs_host_inst.tx(wb[i], k);
		rfs_host_inst.ss(1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		rfs_host_inst.ss(1'b0);
		rfs_host_inst.tx({`RFS_DEV_ADDR, 1'b0}, k);
		rfs_host_inst.tx(a, k);
		rfs_host_inst.ss(1'b0);
		rfs_host_inst.tx({`RFS_DEV_ADDR, 1'b1}, k);
		for (int i = 0; i < n; i++)
			rfs_host_inst.rx(i == n - 1, rb[i]);
		rfs_host_inst.ss(1'b1);
	endtask
	// budget for nearly twice the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		sd = 32'h0001573d;
		acc = 3'h0;
		rst_b <= 1'b0;
		oc    <= 1'b0;
		tsd   <= 1'b0;
		twrn  <= 1'b0;
		gate  <= 1'b0;
		ok    <= 1'b0;
		// link side needs three of its own edges in reset
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h00, 1);
		chk("diag rst", rb[0], 8'h06);
		rfs_host_inst.ss(1'b0);
		rfs_host_inst.tx(8'h20, k);
		rfs_host_inst.ss(1'b1);
		chk("foreign nak", k, 1'b1);
		for (int t = 0; t < 3; t++) begin
			gate <= 1'b0;
			for (int i = 0; i < 3; i++)
				rnd(wb[i]);
			wr(8'h01, 3);
			gate <= 1'b1;
			chk("cfg", cfg_o, {wb[0][7:3], wb[1][6:0], wb[2]});
			rd(8'h01, 3);
			chk("swcfg", rb[0], wb[0] & 8'hf8);
			chk("stcfg", rb[1], wb[1] & 8'h7f);
			chk("output_level_code", rb[2], wb[2]);
		end
		wb[0] = 8'hff;
		wr(8'h00, 1);
		rd(8'h00, 1);
		chk("diag ro", rb[0], 8'h0e);
		rd(8'h05, 1);
		chk("unmapped", rb[0], 8'h00);
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		chk("cfg rst", cfg_o, 20'h0);
		for (int t = 0; t < 6; t++) begin
			rnd(v);
			f = t == 0 ? 3'h7 : v[2:0];
			gate <= t == 0 ? 1'b1 : v[4];
			ok   <= t == 0 ? 1'b1 : v[3];
			oc   <= f[2];
			tsd  <= f[1];
			twrn <= f[0];
			repeat (10) @(posedge clk);
			oc   <= 1'b0;
			tsd  <= 1'b0;
			twrn <= 1'b0;
			acc = acc | f;
			repeat (10) @(posedge clk);
			rd(8'h00, 1);
			chk("diag", rb[0], dexp(acc, gate, ok));
			chk("flags", flags_o, acc);
			wb[0] = {v[7:1], t[0]};
			wr(8'h04, 1);
			if (t[0])
				acc = 3'h0;
			repeat (10) @(posedge clk);
			chk("flags clr", flags_o, acc);
			rd(8'h04, 1);
			chk("cmd", rb[0], wb[0]);
		end
		// fault still present while cleared: the set must win
		oc <= f[2] | 1'b1;
		repeat (10) @(posedge clk);
		wb[0] = 8'h01;
		wr(8'h04, 1);
		chk("flag held", flags_o, 3'h4);
		oc <= 1'b0;
		repeat (10) @(posedge clk);
		wr(8'h04, 1);
		repeat (10) @(posedge clk);
		chk("flag gone", flags_o, 3'h0);
		report_and_stop();
	end
endmodule
